// *** src/csw_config_port.sv ***
// module: two-wire write-only configuration receiver with output control
`timescale 1ns/1ps
module csw_config_port #(
  parameter int N_OUT = 48
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  // serial link
  input  wire logic             serial_clock_pin_in,
  input  wire logic             serial_data_pin_in,
  output logic                  serial_data_pin_out,
  output logic                  serial_data_pin_oe_out,
  // strap and clock gating
  input  wire logic [2:0]       freq_strap_pins_in,
  input  wire logic [N_OUT-1:0] clk_raw_in,
  // controlled outputs
  output logic [N_OUT-1:0]      clk_pin_out,
  output logic [N_OUT-1:0]      clk_pin_oe_out,
  output logic [2:0]            freq_code_out,
  output logic                  spread_on_out,
  output logic [55:0]           config_out
);
  import csw_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  // idle-high reset values stop a false edge right after reset
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_prev_q, sda_prev_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], serial_clock_pin_in};
      sda_sync_q <= {sda_sync_q[0], serial_data_pin_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end
  wire scl      = scl_sync_q[1];
  wire sda      = sda_sync_q[1];
  wire scl_rise = scl & ~scl_prev_q;
  wire scl_fall = ~scl & scl_prev_q;
  wire start_c  = scl & scl_prev_q & sda_prev_q & ~sda;
  wire stop_c   = scl & scl_prev_q & ~sda_prev_q & sda;

  // ---------------------------------------------------------------
  // byte receiver
  // ---------------------------------------------------------------
  csw_state_e state_q, state_d;
  logic [7:0]  shift_q, shift_d;
  logic [2:0]  bit_q, bit_d;
  logic [3:0]  pos_q, pos_d;
  logic        ack_q, ack_d;
  logic [55:0] cfg_q, cfg_d;

  wire [7:0] byte_in   = {shift_q[6:0], sda};
  wire       byte_done = scl_rise & (bit_q == 3'h7);
  wire       addr_ok   = (byte_in == CSW_SLAVE_ADDR);
  wire       is_addr   = (pos_q == CSW_POS_ADDR);
  wire       is_data   = (pos_q >= CSW_POS_DATA0);
  wire [2:0] data_idx  = 3'(pos_q - CSW_POS_DATA0);

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bit_d   = bit_q;
    pos_d   = pos_q;
    ack_d   = ack_q;
    cfg_d   = cfg_q;
    case (state_q)
      CSW_IDLE: begin
        ack_d = 1'b0;
      end
      CSW_RECV: begin
        if (scl_rise) begin
          shift_d = byte_in;
          bit_d   = 3'(bit_q + 3'h1);
        end
        if (byte_done) begin
          if (is_addr && !addr_ok) begin
            state_d = CSW_SKIP;
          end else begin
            state_d = CSW_ACK;
            if (is_data) begin
              cfg_d[8*data_idx +: 8] = byte_in;
            end
          end
        end
      end
      CSW_ACK: begin
        // first fall pulls data low, the next one lets it go
        if (scl_fall) begin
          ack_d = ~ack_q;
          if (ack_q) begin
            state_d = (pos_q == CSW_POS_LAST) ? CSW_SKIP : CSW_RECV;
            pos_d   = 4'(pos_q + 4'h1);
          end
        end
      end
      CSW_SKIP: begin
        ack_d = 1'b0;
      end
      default: begin
        state_d = CSW_IDLE;
      end
    endcase
    // start or stop anywhere aborts the frame; bytes already stored
    // stay, so a cut frame leaves a partial update behind
    if (start_c) begin
      state_d = CSW_RECV;
      bit_d   = 3'h0;
      pos_d   = CSW_POS_ADDR;
      ack_d   = 1'b0;
    end else if (stop_c) begin
      state_d = CSW_IDLE;
      ack_d   = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_q <= CSW_IDLE;
      shift_q <= 8'h00;
      bit_q   <= 3'h0;
      pos_q   <= 4'h0;
      ack_q   <= 1'b0;
      cfg_q   <= {CSW_RST_B6, CSW_RST_B5, CSW_RST_B4, CSW_RST_B3,
                  CSW_RST_B2, CSW_RST_B1, CSW_RST_B0};
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_q   <= bit_d;
      pos_q   <= pos_d;
      ack_q   <= ack_d;
      cfg_q   <= cfg_d;
    end
  end

  // open-drain data: only ever pulls low for ack, never returns data
  assign serial_data_pin_out    = 1'b0;
  assign serial_data_pin_oe_out = ack_q;

  // ---------------------------------------------------------------
  // frequency selection with gradual stepping
  // ---------------------------------------------------------------
  logic [2:0] strap_q;
  logic [2:0] strap_s_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      strap_s_q <= 3'h0;
      strap_q   <= 3'h0;
    end else begin
      strap_s_q <= freq_strap_pins_in;
      strap_q   <= strap_s_q;
    end
  end

  wire       use_reg   = cfg_q[CSW_B0_SRC_BIT];
  wire [2:0] reg_sel   = cfg_q[CSW_B0_SEL_LSB +: 3];
  wire [2:0] target    = use_reg ? reg_sel : strap_q;
  wire [1:0] func_sel  = cfg_q[1:0];

  // shared decode of the output function field
  function automatic logic fn_is(input logic [1:0] fld,
                                 input logic [1:0] code);
    return fld == code;
  endfunction

  logic [2:0] freq_q;
  logic [9:0] ramp_q;
  wire        ramp_tick = (ramp_q == CSW_RAMP_LAST);
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      freq_q <= 3'h0;
      ramp_q <= 10'h000;
    end else begin
      ramp_q <= ramp_tick ? 10'h000 : 10'(ramp_q + 10'h001);
      if (ramp_tick && freq_q != target) begin
        // one code step per period avoids an abrupt jump
        freq_q <= (freq_q < target) ? 3'(freq_q + 3'h1)
                                    : 3'(freq_q - 3'h1);
      end
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  assign freq_code_out = freq_q;
  assign spread_on_out = fn_is(func_sel, CSW_FN_SPREAD);
  assign config_out    = cfg_q;

  // ---------------------------------------------------------------
  // output gating
  // ---------------------------------------------------------------
  wire             tri_all = fn_is(func_sel, CSW_FN_TRISTATE);
  // bytes 1..6 map in order onto the outputs; reserved bits are
  // written as zero by the master, so they simply read as disabled
  wire [N_OUT-1:0] en_bits = cfg_q[CSW_BYTE_BITS +: N_OUT];
  assign clk_pin_out    = clk_raw_in & en_bits;
  assign clk_pin_oe_out = {N_OUT{~tri_all}};
endmodule

// *** src/csw_pkg.sv ***
// package: constants for the clock synthesizer configuration write port
package csw_pkg;
  // ---------------------------------------------------------------
  // transfer layout
  // ---------------------------------------------------------------
  localparam int          CSW_BYTE_BITS   = 8;
  localparam int          CSW_DATA_BYTES  = 7;
  localparam logic [7:0]  CSW_SLAVE_ADDR  = 8'hd2;
  localparam logic [3:0]  CSW_POS_ADDR    = 4'h0;
  localparam logic [3:0]  CSW_POS_DATA0   = 4'h3;
  localparam logic [3:0]  CSW_POS_LAST    = 4'h9;
  // ---------------------------------------------------------------
  // data byte 0 field positions
  // ---------------------------------------------------------------
  localparam int          CSW_B0_SEL_LSB  = 4;
  localparam int          CSW_B0_SRC_BIT  = 3;
  localparam logic [1:0]  CSW_FN_NORMAL   = 2'h0;
  localparam logic [1:0]  CSW_FN_SPREAD   = 2'h2;
  localparam logic [1:0]  CSW_FN_TRISTATE = 2'h3;
  // ---------------------------------------------------------------
  // reset values of data bytes 0..6
  // ---------------------------------------------------------------
  localparam logic [7:0]  CSW_RST_B0      = 8'h00;
  localparam logic [7:0]  CSW_RST_B1      = 8'h0f;
  localparam logic [7:0]  CSW_RST_B2      = 8'h5f;
  localparam logic [7:0]  CSW_RST_B3      = 8'hff;
  localparam logic [7:0]  CSW_RST_B4      = 8'hff;
  localparam logic [7:0]  CSW_RST_B5      = 8'hff;
  localparam logic [7:0]  CSW_RST_B6      = 8'hff;
  // ---------------------------------------------------------------
  // frequency stepping: one code step per ramp period
  // ---------------------------------------------------------------
  localparam int          CSW_RAMP_NS     = 1000;
  localparam int          CSW_CLK_NS      = 10;
  localparam int          CSW_RAMP_CYC    = CSW_RAMP_NS / CSW_CLK_NS;
  localparam logic [9:0]  CSW_RAMP_LAST   = 10'(CSW_RAMP_CYC - 1);
  typedef enum logic [3:0] {
    CSW_IDLE = 4'h1,
    CSW_RECV = 4'h2,
    CSW_ACK  = 4'h4,
    CSW_SKIP = 4'h8
  } csw_state_e;
endpackage

// *** verification/csw_config_port_chk_sva.sv ***
// checker: port-level assertions for the config write port
`timescale 1ns/1ps
module csw_config_port_chk
  import csw_pkg::*;
#(parameter int N_OUT = 48) (
  input wire logic             core_clk_in,
  input wire logic             resetn_in,
  input wire logic             serial_clock_pin_in,
  input wire logic             serial_data_pin_in,
  input wire logic             serial_data_pin_out,
  input wire logic             serial_data_pin_oe_out,
  input wire logic [2:0]       freq_strap_pins_in,
  input wire logic [N_OUT-1:0] clk_raw_in,
  input wire logic [N_OUT-1:0] clk_pin_out,
  input wire logic [N_OUT-1:0] clk_pin_oe_out,
  input wire logic [2:0]       freq_code_out,
  input wire logic             spread_on_out,
  input wire logic [55:0]      config_out
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  wire fn_off = config_out[1:0] == CSW_FN_TRISTATE;
  // reset check must run while reset is low
  AST_RST_DEF: assert property (disable iff (1'b0)
    !resetn_in |=> config_out == 56'hffffffff5f0f00) else $error("no defaults");
  AST_OD_LOW: assert property (serial_data_pin_out == 1'b0)
    else $error("data pin driven high");
  AST_ACK_EDGE: assert property ($rose(serial_data_pin_oe_out) |->
    !serial_clock_pin_in) else $error("ack raised with clock high");
  AST_ACK_HOLD: assert property ($rose(serial_data_pin_oe_out) |=>
    serial_data_pin_oe_out[*6]) else $error("ack too short");
  AST_GATE: assert property (clk_pin_out ==
    (clk_raw_in & config_out[8 +: N_OUT])) else $error("gating wrong");
  // one cycle of slack; the enable is decoded from config_out with no register
  AST_TRI: assert property (fn_off[*2] |-> clk_pin_oe_out == '0)
    else $error("outputs not floated");
  AST_SPREAD: assert property ($stable(config_out) |->
    spread_on_out == (config_out[1:0] == CSW_FN_SPREAD)) else $error("spread");
  AST_FSTEP: assert property ($changed(freq_code_out) |->
    3'(freq_code_out - $past(freq_code_out)) inside {3'h1, 3'h7})
    else $error("frequency jump");
  AST_FHOLD: assert property ($changed(freq_code_out) |=>
    $stable(freq_code_out)[*8]) else $error("steps too fast");
  AST_QUIET: assert property (serial_clock_pin_in[*8] |->
    $stable(config_out)) else $error("config moved with link idle");
endmodule

// *** verification/csw_config_port_tb.sv ***
// testbench: configuration frames through the two-wire write port
`timescale 1ns/1ps
module csw_config_port_tb;
  localparam int N_OUT = 48;
  logic             clk;
  logic             rstn;
  logic [2:0]       strap;
  logic [N_OUT-1:0] raw;
  logic             scl;
  wire              sda;
  logic             oe;
  logic [N_OUT-1:0] gclk;
  logic [N_OUT-1:0] goe;
  logic [2:0]       fcode;
  logic             spread;
  logic [55:0]      cfg;
  logic [9:0]       acks;
  int               mismatches;
  int               n_compared;
  csw_config_port #(.N_OUT(N_OUT)) csw_config_port_i (
    .core_clk_in(clk), .resetn_in(rstn), .serial_clock_pin_in(scl),
    .serial_data_pin_in(sda), .serial_data_pin_out(),
    .serial_data_pin_oe_out(oe), .freq_strap_pins_in(strap),
    .clk_raw_in(raw), .clk_pin_out(gclk), .clk_pin_oe_out(goe),
    .freq_code_out(fcode), .spread_on_out(spread), .config_out(cfg));
  csw_master_model m_i (.clk_in(clk), .sda_oe_in(oe), .scl_out(scl),
    .sda_out(sda));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // command and count bytes carry junk; the port must skip them
  task automatic frame(input logic [7:0] a, input logic [55:0] dv);
    logic ak;
    m_i.start();
    for (int i = 0; i < 10; i++) begin
      m_i.wbyte(i == 0 ? a : i == 1 ? 8'ha5 : i == 2 ? 8'h3c :
        dv[8*(i-3) +: 8], ak);
      acks[i] = ak;
    end
    m_i.stop();
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    results();
  end
  initial begin
    rstn = 1'b0;
    strap = 3'h2;
    raw = '1;
    mismatches = 0;
    n_compared = 0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (300) @(negedge clk);
    check(cfg, 56'hffffffff5f0f00);
    check(fcode, 3'h2);
    frame(8'hd0, '0);
    check(acks, 10'h0);
    frame(8'hd3, '0);
    check(cfg, 56'hffffffff5f0f00);
    frame(8'hd2, 56'h18c37e8153055a);
    check(acks, 10'h3ff);
    check(cfg, 56'h18c37e8153055a);
    check(gclk, 48'h18c37e815305);
    check(spread, 1'b1);
    repeat (600) @(negedge clk);
    check(fcode, 3'h5);
    for (int f = 0; f < 4; f++) begin
      frame(8'hd2, {48'hffffffff5f0f, 8'(f)});
      check(goe, {N_OUT{f != 3}});
      check(spread, f == 2);
      check(gclk, 48'hffffffff5f0f);
    end
    check(fcode, 3'h2);
    raw = 48'h3c3c3c3ca5a5;
    @(negedge clk);
    check(gclk, 48'h3c3c3c3c0505);
    results();
  end
endmodule
bind csw_config_port csw_config_port_chk #(.N_OUT(N_OUT)) chk_i (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .serial_clock_pin_in(serial_clock_pin_in),
  .serial_data_pin_in(serial_data_pin_in),
  .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe_out(serial_data_pin_oe_out),
  .freq_strap_pins_in(freq_strap_pins_in), .clk_raw_in(clk_raw_in),
  .clk_pin_out(clk_pin_out), .clk_pin_oe_out(clk_pin_oe_out),
  .freq_code_out(freq_code_out), .spread_on_out(spread_on_out),
  .config_out(config_out));

// *** verification/csw_master_model.sv ***
// partner: two-wire bus master that writes configuration frames
`timescale 1ns/1ps
module csw_master_model (
  input  wire logic clk_in,
  input  wire logic sda_oe_in,
  output logic      scl_out,
  output wire logic sda_out
);
  logic sda_drv_q;
  // released line floats high through the pull-up
  assign sda_out = sda_drv_q & ~sda_oe_in;
  initial begin
    scl_out = 1'b1; // clock stands still between frames
    sda_drv_q = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic start();
    sda_drv_q = 1'b0;
    wt(8);
    scl_out = 1'b0;
  endtask
  // ninth slot releases data so the slave can acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic [8:0] v;
    v = {b, 1'b1};
    // 125 ns bit period; the offsets keep every link edge clear of
    // both core clock edges
    wt(1);
    #1.25;
    for (int i = 8; i >= 0; i--) begin
      #30;
      sda_drv_q = v[i];
      #32.5;
      scl_out = 1'b1;
      #30;
      ack = sda_out === 1'b0;
      #32.5;
      scl_out = 1'b0;
    end
  endtask
  task automatic stop();
    wt(4);
    sda_drv_q = 1'b0;
    wt(4);
    scl_out = 1'b1;
    wt(8);
    sda_drv_q = 1'b1;
    wt(8);
  endtask
endmodule
